// ===== nvp_chk.sv
// assertion checker for the serial programming port, bound to nvp_port
// assumes prog_clock halves of at least four system cycles
`timescale 1ns/1ps
`default_nettype none
module nvp_chk (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_prog_clock,
	input wire logic i_prog_data,
	input wire logic o_prog_data,
	input wire logic o_prog_data_oe_n,
	input wire logic o_ee_busy
);
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	logic pc_q;
	logic [7:0] since_fall;
	logic [5:0] oe_edges;
	logic [5:0] busy_edges;
	wire logic raw_fall = pc_q & ~i_prog_clock;
	always_ff @(posedge i_sys_clk) begin
		pc_q <= i_prog_clock;
	end
	// saturates so a long idle cannot wrap into a false match
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			since_fall <= 8'hFF;
		end else if (raw_fall) begin
			since_fall <= 8'h00;
		end else if (since_fall != 8'hFF) begin
			since_fall <= since_fall + 8'h01;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || o_prog_data_oe_n) begin
			oe_edges <= 6'h00;
		end else if (raw_fall) begin
			oe_edges <= oe_edges + 6'h01;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !o_ee_busy) begin
			busy_edges <= 6'h00;
		end else if (raw_fall && busy_edges != 6'h3F) begin
			busy_edges <= busy_edges + 6'h01;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	sequence oe_hold_low; !o_prog_data_oe_n [*8]; endsequence
	sequence oe_hold_high; o_prog_data_oe_n [*8]; endsequence
	sequence busy_hold; o_ee_busy [*8]; endsequence
	chk_reset_quiet:
	assert property ($rose(i_rstn) |-> o_prog_data_oe_n && !o_ee_busy) else $error("outputs active after reset");
	chk_turn_clock_low:
	assert property ($fell(o_prog_data_oe_n) |-> !i_prog_clock) else $error("line turned while clock high");
	chk_oe_low_hold:
	assert property ($fell(o_prog_data_oe_n) |-> oe_hold_low) else $error("drive window too short");
	chk_oe_eight_clocks:
	assert property ($rose(o_prog_data_oe_n) |-> oe_edges == 6'h08) else $error("drive window not eight clocks");
	chk_oe_gap_high:
	assert property ($rose(o_prog_data_oe_n) |-> oe_hold_high) else $error("line driven again too soon");
	chk_data_on_edge:
	assert property ($changed(o_prog_data) && !o_prog_data_oe_n && !$past(o_prog_data_oe_n) |-> since_fall <= 8'h0A)
		else $error("out bit changed away from a falling edge");
	chk_busy_from_edge:
	assert property ($rose(o_ee_busy) |-> since_fall <= 8'h0A) else $error("write started away from an edge");
	chk_busy_min_hold:
	assert property ($rose(o_ee_busy) |-> busy_hold) else $error("busy too short");
	chk_busy_after_24:
	assert property ($fell(o_ee_busy) |-> busy_edges >= 6'h18) else $error("write ended before 24 clocks");
endmodule : nvp_chk
bind nvp_port nvp_chk nvp_chk_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_prog_clock(i_prog_clock),
	.i_prog_data(i_prog_data), .o_prog_data(o_prog_data), .o_prog_data_oe_n(o_prog_data_oe_n), .o_ee_busy(o_ee_busy));
`default_nettype wire

// ===== nvp_mem.sv
// single-port byte memory, registered read data
// assumes one access per cycle from the owning block
`timescale 1ns/1ps
`default_nettype none
module nvp_mem #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_en,
	input wire logic i_we,
	input wire logic [AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge i_sys_clk) begin
		if (i_en) begin
			if (i_we) begin
				mem[i_addr] <= i_wdata;
			end else begin
				o_rdata <= mem[i_addr];
			end
		end
	end
endmodule : nvp_mem
`default_nettype wire

// ===== nvp_pkg.sv
// package of constants for the serial nonvolatile programming port
// assumes a 100 MHz system clock; no other dependency
`default_nettype none
package nvp_pkg;

	// ----------------------------------------
	// serial framing
	// ----------------------------------------
	localparam int CMD_BITS = 4;
	localparam int OPERAND_BITS = 16;
	localparam int FRAME_BITS = CMD_BITS + OPERAND_BITS;
	localparam int FETCH_CLOCKS = 8;
	localparam logic [4:0] LAST_CMD_EDGE = 5'h03;
	localparam logic [4:0] TURN_EDGE = 5'h0B;
	localparam logic [4:0] LAST_FRAME_EDGE = 5'h13;

	// ----------------------------------------
	// four-bit commands
	// ----------------------------------------
	localparam logic [3:0] CMD_CORE = 4'h0;
	localparam logic [3:0] CMD_SHIFT_HOLD = 4'h2;
	localparam logic [3:0] CMD_TBL_READ = 4'h9;
	localparam logic [3:0] CMD_TBL_WR_GO = 4'hF;

	// ----------------------------------------
	// core instruction subset
	// ----------------------------------------
	localparam logic [7:0] OP_MOVLW = 8'h0E;
	localparam logic [7:0] OP_MOVWF = 8'h6E;
	localparam logic [3:0] OP_BSF = 4'h8;
	localparam logic [3:0] OP_BCF = 4'h9;
	localparam logic [5:0] OP_MOVF = 6'h14;

	// ----------------------------------------
	// special register addresses
	// ----------------------------------------
	localparam logic [7:0] SFR_CTRL = 8'hA6;
	localparam logic [7:0] SFR_NV_DATA = 8'hA8;
	localparam logic [7:0] SFR_NV_PTR_LO = 8'hA9;
	localparam logic [7:0] SFR_NV_PTR_HI = 8'hAA;
	localparam logic [7:0] SFR_HOLD = 8'hF5;
	localparam logic [7:0] SFR_TP_LO = 8'hF6;
	localparam logic [7:0] SFR_TP_HI = 8'hF7;
	localparam logic [7:0] SFR_TP_UP = 8'hF8;

	// ----------------------------------------
	// memory_access_control fields
	// ----------------------------------------
	localparam int CTRL_FLASH_SEL = 7;
	localparam int CTRL_CFG_SEL = 6;
	localparam int CTRL_PROG_EN = 2;
	localparam int CTRL_GO = 1;
	localparam int CTRL_READ = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;

	// ----------------------------------------
	// address space
	// ----------------------------------------
	localparam int ADDR_BITS = 22;
	localparam logic [21:0] CFG_BASE = 22'h30_0000;
	localparam int CFG_BYTES = 16;
	localparam logic [3:0] CFG_PROT_INDEX = 4'hB;
	localparam int CFG_PROT_BIT = 5;
	localparam logic [7:0] CFG_RESET = 8'hFF;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [21:0] DEVID_LO_ADDR = 22'h3F_FFFE;
	localparam logic [21:0] DEVID_HI_ADDR = 22'h3F_FFFF;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam logic [4:0] EE_START_EDGE = 5'h18;
	localparam int CLK_PERIOD_NS = 10;
	localparam int EE_WRITE_TIME_NS = 4000000;
	localparam int EE_WRITE_CYCLES = EE_WRITE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		EE_IDLE = 3'b000,
		EE_WAIT = 3'b001,
		EE_ERASE = 3'b011,
		EE_STORE = 3'b010,
		EE_BUSY = 3'b110
	} nvp_ee_state_t;

endpackage : nvp_pkg
`default_nettype wire

// ===== nvp_port.sv
// serial programming port: command engine, pointers, data eeprom and configuration bytes
// assumes an external programmer drives prog_clock and prog_data_line, one bit per clock
//
// How it works
// - a data eeprom byte write erases the byte, then stores the new value
// - program enable must be set first; every write is refused while clear
// - programmer starts an eeprom write by setting the go bit
// - write starts on 24th falling clock after go; go clears when done
// - configuration written a byte at a time by command 1111
// - even address takes low operand byte, odd address the high byte
// - configuration writes never advance the pointer
// - once configuration protect bit is zero, configuration writes are blocked
// - command 1001 fetches the table byte and drives it out serially
// - command bits arrive least significant bit first
// - fetch on the last command falling edge, shift out over last eight
// - data line turns to output after the eighth operand falling edge
// - each table read advances the table pointer by one
// - table reads reach the whole 22-bit address space
// - read start loads the data latch from eeprom for shift-out by 0010
// - command 0010 sends the holding latch in the high operand byte
// - command 0000 executes its operand as a core instruction
`timescale 1ns/1ps
`default_nettype none
module nvp_port #(
	parameter int EE_DEPTH = 256,
	parameter int EE_AW = 8,
	parameter int EE_WRITE_CYCLES = nvp_pkg::EE_WRITE_CYCLES,
	parameter logic [15:0] DEV_ID = 16'h0000 // arbitrary value
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_prog_clock,
	input wire logic i_prog_data,
	output logic o_prog_data,
	output logic o_prog_data_oe_n,
	output logic o_ee_busy
);
	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic clk_lvl;
	logic din;
	logic clk_prev;
	logic fall;

	nvp_sync u_sync_clk (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pin(i_prog_clock),
		.o_level(clk_lvl)
	);
	nvp_sync u_sync_dat (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pin(i_prog_data),
		.o_level(din)
	);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= clk_lvl;
		end
	end
	assign fall = clk_prev & ~clk_lvl;

	// ----------------------------------------
	// frame shifter
	// ----------------------------------------
	logic [4:0] bit_cnt;
	logic [3:0] cmd;
	logic [15:0] opnd;
	logic [3:0] cmd_now;
	logic [15:0] opnd_full;
	logic cmd_edge;
	logic done;

	assign cmd_now = {din, cmd[2:0]};
	assign opnd_full = {din, opnd[14:0]};
	assign cmd_edge = fall && (bit_cnt == nvp_pkg::LAST_CMD_EDGE);
	assign done = fall && (bit_cnt == nvp_pkg::LAST_FRAME_EDGE);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			bit_cnt <= 5'h00;
			cmd <= 4'h0;
			opnd <= 16'h0000;
		end else if (fall) begin
			if (bit_cnt < 5'(nvp_pkg::CMD_BITS)) begin
				cmd[bit_cnt[1:0]] <= din;
			end else begin
				opnd[4'(bit_cnt - 5'(nvp_pkg::CMD_BITS))] <= din;
			end
			bit_cnt <= done ? 5'h00 : bit_cnt + 5'h01;
		end
	end

	// ----------------------------------------
	// registers reached by core instructions
	// ----------------------------------------
	logic [7:0] ctrl;
	logic [7:0] w_reg;
	logic [7:0] nv_ptr_lo;
	logic [7:0] nv_ptr_hi;
	logic [7:0] nv_data;
	logic [7:0] hold;
	logic [5:0] tp_up;
	logic [7:0] tp_hi;
	logic [7:0] tp_lo;
	logic [21:0] tp;
	logic [7:0] cfg_mem [nvp_pkg::CFG_BYTES];

	logic core;
	logic [7:0] op;
	logic [7:0] fa;
	logic [7:0] sfr_rd;
	logic [7:0] bit_mask;
	logic sfr_we;
	logic [7:0] sfr_wdata;

	assign tp = {tp_up, tp_hi, tp_lo};
	assign core = done && (cmd == nvp_pkg::CMD_CORE);
	assign op = opnd_full[15:8];
	assign fa = opnd_full[7:0];
	assign bit_mask = 8'h01 << op[3:1];

	always_comb begin
		if (fa == nvp_pkg::SFR_CTRL) begin
			sfr_rd = ctrl;
		end else if (fa == nvp_pkg::SFR_NV_DATA) begin
			sfr_rd = nv_data;
		end else if (fa == nvp_pkg::SFR_NV_PTR_LO) begin
			sfr_rd = nv_ptr_lo;
		end else if (fa == nvp_pkg::SFR_NV_PTR_HI) begin
			sfr_rd = nv_ptr_hi;
		end else if (fa == nvp_pkg::SFR_HOLD) begin
			sfr_rd = hold;
		end else if (fa == nvp_pkg::SFR_TP_LO) begin
			sfr_rd = tp_lo;
		end else if (fa == nvp_pkg::SFR_TP_HI) begin
			sfr_rd = tp_hi;
		end else if (fa == nvp_pkg::SFR_TP_UP) begin
			sfr_rd = {2'b00, tp_up};
		end else begin
			sfr_rd = 8'h00;
		end
	end

	// decode of the executed instruction
	always_comb begin
		sfr_we = 1'b0;
		sfr_wdata = w_reg;
		if (core) begin
			if (op == nvp_pkg::OP_MOVWF) begin
				sfr_we = 1'b1;
			end else if (op[7:4] == nvp_pkg::OP_BSF) begin
				sfr_we = 1'b1;
				sfr_wdata = sfr_rd | bit_mask;
			end else if (op[7:4] == nvp_pkg::OP_BCF) begin
				sfr_we = 1'b1;
				sfr_wdata = sfr_rd & ~bit_mask;
			end
		end
	end

	function automatic logic sfr_hit(input logic we, input logic [7:0] a, input logic [7:0] r);
		sfr_hit = we && (a == r);
	endfunction : sfr_hit

	function automatic logic is_cfg(input logic [21:0] a);
		is_cfg = (a[21:4] == nvp_pkg::CFG_BASE[21:4]);
	endfunction : is_cfg

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			w_reg <= nvp_pkg::LATCH_RESET;
		end else if (core && op == nvp_pkg::OP_MOVLW) begin
			w_reg <= fa;
		end else if (core && op[7:2] == nvp_pkg::OP_MOVF) begin
			w_reg <= sfr_rd;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			nv_ptr_lo <= nvp_pkg::LATCH_RESET;
			nv_ptr_hi <= nvp_pkg::LATCH_RESET;
			hold <= nvp_pkg::LATCH_RESET;
		end else begin
			if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_NV_PTR_LO)) begin
				nv_ptr_lo <= sfr_wdata;
			end
			if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_NV_PTR_HI)) begin
				nv_ptr_hi <= sfr_wdata;
			end
			if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_HOLD)) begin
				hold <= sfr_wdata;
			end
		end
	end

	// table pointer: loaded by core, advanced by each table read
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			{tp_up, tp_hi, tp_lo} <= 22'h00_0000;
		end else if (done && cmd == nvp_pkg::CMD_TBL_READ) begin
			{tp_up, tp_hi, tp_lo} <= tp + 22'h00_0001;
		end else begin
			if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_TP_LO)) begin
				tp_lo <= sfr_wdata;
			end
			if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_TP_HI)) begin
				tp_hi <= sfr_wdata;
			end
			if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_TP_UP)) begin
				tp_up <= sfr_wdata[5:0];
			end
		end
	end

	// ----------------------------------------
	// configuration bytes
	// ----------------------------------------
	logic cfg_wr;
	logic cfg_locked;

	assign cfg_locked = !cfg_mem[nvp_pkg::CFG_PROT_INDEX][nvp_pkg::CFG_PROT_BIT];
	assign cfg_wr = done && (cmd == nvp_pkg::CMD_TBL_WR_GO)
		&& ctrl[nvp_pkg::CTRL_FLASH_SEL] && ctrl[nvp_pkg::CTRL_CFG_SEL]
		&& ctrl[nvp_pkg::CTRL_PROG_EN]
		&& is_cfg(tp) && !cfg_locked;

	// pointer is left alone here, so each byte needs a fresh address
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < nvp_pkg::CFG_BYTES; i++) begin
				cfg_mem[i] <= nvp_pkg::CFG_RESET;
			end
		end else if (cfg_wr) begin
			cfg_mem[tp[3:0]] <= tp[0] ? opnd_full[15:8] : opnd_full[7:0];
		end
	end

	// ----------------------------------------
	// table lookup and serial output
	// ----------------------------------------
	logic [7:0] tbl_data;
	logic [7:0] shift;

	// code space is not stored here, so it reads as erased
	always_comb begin
		if (is_cfg(tp)) begin
			tbl_data = cfg_mem[tp[3:0]];
		end else if (tp == nvp_pkg::DEVID_LO_ADDR) begin
			tbl_data = DEV_ID[7:0];
		end else if (tp == nvp_pkg::DEVID_HI_ADDR) begin
			tbl_data = DEV_ID[15:8];
		end else begin
			tbl_data = nvp_pkg::BLANK_BYTE;
		end
	end

	logic out_cmd;
	assign out_cmd = (cmd == nvp_pkg::CMD_TBL_READ) || (cmd == nvp_pkg::CMD_SHIFT_HOLD);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			shift <= 8'h00;
		end else if (cmd_edge) begin
			shift <= (cmd_now == nvp_pkg::CMD_TBL_READ) ? tbl_data : hold;
		end else if (fall && out_cmd && bit_cnt > nvp_pkg::TURN_EDGE) begin
			shift <= {1'b0, shift[7:1]};
		end
	end

	// turn the line round after the eighth operand falling edge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_prog_data_oe_n <= 1'b1;
			o_prog_data <= 1'b0;
		end else begin
			if (fall && out_cmd && bit_cnt == nvp_pkg::TURN_EDGE) begin
				o_prog_data_oe_n <= 1'b0;
			end else if (done) begin
				o_prog_data_oe_n <= 1'b1;
			end
			o_prog_data <= shift[0];
		end
	end

	// ----------------------------------------
	// data eeprom
	// ----------------------------------------
	nvp_pkg::nvp_ee_state_t ee_state;
	logic [4:0] edge_cnt;
	logic [31:0] busy_cnt;
	logic ee_done;
	logic ee_refuse;
	logic ee_space;
	logic rd_issue;
	logic rd_pend;
	logic mem_en;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;

	assign ee_space = !ctrl[nvp_pkg::CTRL_FLASH_SEL] && !ctrl[nvp_pkg::CTRL_CFG_SEL];
	// only data eeprom writes are carried out; any other go is dropped
	assign ee_refuse = (ee_state == nvp_pkg::EE_IDLE) && ctrl[nvp_pkg::CTRL_GO]
		&& !(ctrl[nvp_pkg::CTRL_PROG_EN] && ee_space);
	assign rd_issue = ctrl[nvp_pkg::CTRL_READ] && (ee_state == nvp_pkg::EE_IDLE);
	assign ee_done = (ee_state == nvp_pkg::EE_BUSY) && (busy_cnt == 32'(EE_WRITE_CYCLES - 1));

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			ee_state <= nvp_pkg::EE_IDLE;
			edge_cnt <= 5'h00;
			busy_cnt <= 32'h0000_0000;
		end else begin
			case (ee_state)
				nvp_pkg::EE_IDLE: begin
					edge_cnt <= 5'h00;
					if (ctrl[nvp_pkg::CTRL_GO] && !ee_refuse) begin
						ee_state <= nvp_pkg::EE_WAIT;
					end
				end
				nvp_pkg::EE_WAIT: begin
					if (fall) begin
						edge_cnt <= edge_cnt + 5'h01;
						if (edge_cnt == nvp_pkg::EE_START_EDGE - 5'h01) begin
							ee_state <= nvp_pkg::EE_ERASE;
						end
					end
				end
				nvp_pkg::EE_ERASE: begin
					ee_state <= nvp_pkg::EE_STORE;
				end
				nvp_pkg::EE_STORE: begin
					busy_cnt <= 32'h0000_0000;
					ee_state <= nvp_pkg::EE_BUSY;
				end
				nvp_pkg::EE_BUSY: begin
					busy_cnt <= busy_cnt + 32'h0000_0001;
					if (ee_done) begin
						ee_state <= nvp_pkg::EE_IDLE;
					end
				end
				default: begin
					ee_state <= nvp_pkg::EE_IDLE;
				end
			endcase
		end
	end

	assign o_ee_busy = (ee_state != nvp_pkg::EE_IDLE);

	always_comb begin
		mem_en = 1'b0;
		mem_we = 1'b0;
		mem_wdata = nvp_pkg::BLANK_BYTE;
		if (ee_state == nvp_pkg::EE_ERASE) begin
			mem_en = 1'b1;
			mem_we = 1'b1;
		end else if (ee_state == nvp_pkg::EE_STORE) begin
			mem_en = 1'b1;
			mem_we = 1'b1;
			mem_wdata = nv_data;
		end else if (rd_issue && ee_space) begin
			mem_en = 1'b1;
		end
	end

	nvp_mem #(
		.DEPTH(EE_DEPTH),
		.AW(EE_AW)
	) u_ee_mem (
		.i_sys_clk(i_sys_clk),
		.i_en(mem_en),
		.i_we(mem_we),
		.i_addr(EE_AW'({nv_ptr_hi, nv_ptr_lo})),
		.i_wdata(mem_wdata),
		.o_rdata(mem_rdata)
	);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rd_pend <= 1'b0;
			nv_data <= nvp_pkg::LATCH_RESET;
		end else begin
			rd_pend <= rd_issue && ee_space;
			if (rd_pend) begin
				nv_data <= mem_rdata;
			end else if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_NV_DATA)) begin
				nv_data <= sfr_wdata;
			end
		end
	end

	// a core write carries a stale copy of go and read; it must not undo the hardware clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			ctrl <= nvp_pkg::CTRL_RESET;
		end else if (sfr_hit(sfr_we, fa, nvp_pkg::SFR_CTRL)) begin
			ctrl <= sfr_wdata;
			ctrl[nvp_pkg::CTRL_GO] <= sfr_wdata[nvp_pkg::CTRL_GO] && !(ee_done || ee_refuse);
			ctrl[nvp_pkg::CTRL_READ] <= sfr_wdata[nvp_pkg::CTRL_READ] && !rd_issue;
		end else begin
			if (ee_done || ee_refuse) begin
				ctrl[nvp_pkg::CTRL_GO] <= 1'b0;
			end
			if (rd_issue) begin
				ctrl[nvp_pkg::CTRL_READ] <= 1'b0;
			end
		end
	end

endmodule : nvp_port
`default_nettype wire

// ===== nvp_prog_model.sv
// behavioural programmer driving prog_clock and prog_data_line
// assumes it shares i_sys_clk with the device; clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module nvp_prog_model #(
	parameter int TURN_CYCLES = 20,
	parameter int HALF_CYCLES = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_dev_data,
	input wire logic i_dev_oe_n,
	output logic o_prog_clock,
	output logic o_line
);
	logic drv_en;
	logic drv_bit;
	// released line shows the inverse of the last bit, never a stale copy
	assign o_line = !i_dev_oe_n ? i_dev_data : (drv_en ? drv_bit : ~drv_bit);
	initial begin
		o_prog_clock = 1'b0;
		drv_en = 1'b1;
		drv_bit = 1'b0;
	end
	// ----------------------------------------
	// one frame: four command bits, sixteen operand bits
	// ----------------------------------------
	task automatic frame(input logic [3:0] cmd, input logic [15:0] opd, output logic [7:0] rd);
		logic [19:0] bits;
		logic rd_cmd;
		bits = {opd, cmd};
		rd_cmd = (cmd == nvp_pkg::CMD_TBL_READ) || (cmd == nvp_pkg::CMD_SHIFT_HOLD);
		rd = 8'h00;
		for (int i = 0; i < 20; i++) begin
			if (rd_cmd && i == 12) begin
				drv_en <= 1'b0;
				repeat (TURN_CYCLES) @(posedge i_sys_clk);
			end
			@(posedge i_sys_clk);
			o_prog_clock <= 1'b1;
			drv_bit <= bits[i];
			repeat (HALF_CYCLES) @(posedge i_sys_clk);
			o_prog_clock <= 1'b0;
			if (rd_cmd && i >= 12) begin
				rd[i-12] = o_line;
			end
			repeat (HALF_CYCLES - 1) @(posedge i_sys_clk);
		end
		drv_en <= 1'b1;
	endtask : frame
	task automatic idle(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask : idle
endmodule : nvp_prog_model
`default_nettype wire

// ===== nvp_sync.sv
// three-stage synchroniser for one pin input
// assumes the input is asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module nvp_sync (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_pin,
	output logic o_level
);
	logic s1;
	logic s2;
	logic s3;

	// first stage feeds only the second
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// change counts once stages two and three agree
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_level <= 1'b0;
		end else if (s2 == s3) begin
			o_level <= s3;
		end
	end
endmodule : nvp_sync
`default_nettype wire

// ===== test_nvp_port.sv
// self-checking bench for nvp_port with a behavioural programmer
// assumes a shortened eeprom write time
`timescale 1ns/1ps
`default_nettype none
module test_nvp_port;
	localparam logic [15:0] DEV_ID = 16'hC35A; // arbitrary value
	logic i_sys_clk;
	logic i_rstn;
	logic prog_clock;
	logic line;
	logic dev_data;
	logic dev_oe_n;
	logic ee_busy;
	logic [7:0] rd;
	int fails;
	int samples_checked;
	nvp_port #(.EE_WRITE_CYCLES(20), .DEV_ID(DEV_ID)) nvp_port_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
		.i_prog_clock(prog_clock), .i_prog_data(line), .o_prog_data(dev_data), .o_prog_data_oe_n(dev_oe_n),
		.o_ee_busy(ee_busy));
	nvp_prog_model nvp_prog_model_inst (.i_sys_clk(i_sys_clk), .i_dev_data(dev_data), .i_dev_oe_n(dev_oe_n),
		.o_prog_clock(prog_clock), .o_line(line));
	initial i_sys_clk = 1'b0;
	always #5 i_sys_clk = ~i_sys_clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic core(input logic [15:0] op);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_CORE, op, rd);
	endtask : core
	task automatic put(input logic [7:0] adr, input logic [7:0] val);
		core({nvp_pkg::OP_MOVLW, val});
		core({nvp_pkg::OP_MOVWF, adr});
	endtask : put
	task automatic ctl(input logic set, input logic [2:0] b);
		core({set ? nvp_pkg::OP_BSF : nvp_pkg::OP_BCF, b, 1'b0, nvp_pkg::SFR_CTRL});
	endtask : ctl
	task automatic peek(input logic [7:0] adr);
		core({nvp_pkg::OP_MOVF, 2'b00, adr});
		core({nvp_pkg::OP_MOVWF, nvp_pkg::SFR_HOLD});
		nvp_prog_model_inst.frame(nvp_pkg::CMD_SHIFT_HOLD, 16'h0000, rd);
	endtask : peek
	task automatic tbl_read(input logic [21:0] a);
		put(nvp_pkg::SFR_TP_UP, {2'b00, a[21:16]});
		put(nvp_pkg::SFR_TP_HI, a[15:8]);
		put(nvp_pkg::SFR_TP_LO, a[7:0]);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_TBL_READ, 16'h0000, rd);
	endtask : tbl_read
	task automatic ee_read(input logic [7:0] a);
		put(nvp_pkg::SFR_NV_PTR_LO, a);
		ctl(1'b1, 3'h0);
		peek(nvp_pkg::SFR_NV_DATA);
	endtask : ee_read
	task automatic ee_write(input logic [7:0] a, input logic [7:0] d, input logic busy_exp);
		put(nvp_pkg::SFR_NV_PTR_LO, a);
		put(nvp_pkg::SFR_NV_DATA, d);
		ctl(1'b1, 3'h1);
		core(16'h0000);
		check({7'h00, ee_busy}, {7'h00, busy_exp});
		core(16'h0000);
		for (int n = 0; n < 400 && ee_busy !== 1'b0; n++) @(posedge i_sys_clk);
		check({7'h00, ee_busy}, 8'h00);
		nvp_prog_model_inst.idle(40);
	endtask : ee_write
	task automatic cfg_write(input logic [7:0] lo, input logic [15:0] d);
		put(nvp_pkg::SFR_TP_UP, 8'h30);
		put(nvp_pkg::SFR_TP_HI, 8'h00);
		put(nvp_pkg::SFR_TP_LO, lo);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_TBL_WR_GO, d, rd);
		core(16'h0000);
		nvp_prog_model_inst.idle(40);
	endtask : cfg_write
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_eeprom;
		ctl(1'b0, 3'h7);
		ctl(1'b0, 3'h6);
		ctl(1'b1, 3'h2);
		ee_write(8'h10, 8'h5A, 1'b1);
		ee_write(8'h10, 8'hA5, 1'b1);
		ee_read(8'h10);
		check(rd, 8'hA5);
		peek(nvp_pkg::SFR_CTRL);
		check(rd, 8'h04);
	endtask : sc_eeprom
	task automatic sc_refused;
		ctl(1'b0, 3'h2);
		ee_write(8'h10, 8'h33, 1'b0);
		ee_read(8'h10);
		check(rd, 8'hA5);
		ctl(1'b1, 3'h2);
		ctl(1'b1, 3'h7);
		ee_write(8'h10, 8'h33, 1'b0);
		ctl(1'b0, 3'h7);
		ee_read(8'h10);
		check(rd, 8'hA5);
	endtask : sc_refused
	task automatic sc_config;
		ctl(1'b1, 3'h7);
		ctl(1'b1, 3'h6);
		cfg_write(8'h00, 16'h1234);
		cfg_write(8'h01, 16'hABCD);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_TBL_READ, 16'h0000, rd);
		check(rd, 8'hAB);
		tbl_read(22'h30_0000);
		check(rd, 8'h34);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_TBL_READ, 16'h0000, rd);
		check(rd, 8'hAB);
		ctl(1'b0, 3'h6);
		put(nvp_pkg::SFR_TP_UP, 8'h00);
		put(nvp_pkg::SFR_TP_HI, 8'h04);
		put(nvp_pkg::SFR_TP_LO, 8'h01);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_TBL_WR_GO, 16'h5566, rd);
		core(16'h0000);
		ctl(1'b1, 3'h6);
		ctl(1'b0, 3'h2);
		cfg_write(8'h01, 16'h9900);
		ctl(1'b1, 3'h2);
		tbl_read(22'h30_0001);
		check(rd, 8'hAB);
		cfg_write(8'h0B, 16'hDF00);
		cfg_write(8'h00, 16'h0077);
		tbl_read(22'h30_0000);
		check(rd, 8'h34);
		tbl_read(22'h30_000B);
		tbl_read(22'h30_000B);
		check(rd, 8'hDF);
	endtask : sc_config
	task automatic sc_far_reads;
		tbl_read(22'h3F_FFFE);
		check(rd, DEV_ID[7:0]);
		nvp_prog_model_inst.frame(nvp_pkg::CMD_TBL_READ, 16'h0000, rd);
		check(rd, DEV_ID[15:8]);
		tbl_read(22'h20_0000);
		check(rd, nvp_pkg::BLANK_BYTE);
		tbl_read(22'h30_0005);
		check(rd, nvp_pkg::CFG_RESET);
	endtask : sc_far_reads
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		fails = 0;
		samples_checked = 0;
		i_rstn = 1'b0;
		repeat (8) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		sc_eeprom();
		sc_refused();
		sc_config();
		sc_far_reads();
		tally_and_finish();
	end
	// the run needs about 30000 cycles
	initial begin
		repeat (90000) @(posedge i_sys_clk);
		fails++;
		tally_and_finish();
	end
endmodule : test_nvp_port
`default_nettype wire
